//--- rtl/nor_seq_params.svh
// constants for the host-side nor flash erase/suspend command sequencer
`ifndef NOR_SEQ_PARAMS_SVH
`define NOR_SEQ_PARAMS_SVH
// command words written on the data pins
`define CMD_UNLK1    16'h00aa
`define CMD_UNLK2    16'h0055
`define CMD_SETUP    16'h0080
`define CMD_CHIP     16'h0010
`define CMD_SUSPEND  16'h00b0
`define CMD_RESUME   16'h0030
`define CMD_ID_ENTRY 16'h0090
`define CMD_SEC_ENTRY 16'h0088
`define CMD_SEC_EXIT 16'h0000
`define CMD_READ_RST 16'h00f0
// word addresses of the unlock cycles and of single-write commands
`define ADDR_UNLK1   12'h555
`define ADDR_UNLK2   12'h2aa
`define ADDR_ANY     12'h000
// status bit position and erased word value
`define DATA_POLL_POS 7
`define ERASED_WORD  16'hffff
// clock period and times
`define CLK_NS       5
`define T_SETUP_NS   10
`define T_WP_NS      35
`define T_ACC_NS     90
`define T_REC_NS     20
`define T_ESUSP_US   20
`define T_PSUSP_US   15
`define T_POLL_NS    1000
`define T_RST_NS     500
`define T_RH_NS      20000
// cycle counts: least times round up, longest times round down
`define SETUP_CYC 8'((`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define WP_CYC    8'((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC   8'((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define REC_CYC   8'((`T_REC_NS + `CLK_NS - 1) / `CLK_NS)
`define ESUSP_CYC 16'((`T_ESUSP_US * 1000) / `CLK_NS)
`define PSUSP_CYC 16'((`T_PSUSP_US * 1000) / `CLK_NS)
`define POLL_CYC  16'((`T_POLL_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_CYC   16'((`T_RST_NS + `CLK_NS - 1) / `CLK_NS)
`define RH_CYC    16'((`T_RH_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- rtl/nor_seq_pkg.sv
// types shared by the nor flash sequencer modules
package nor_seq_pkg;
  typedef enum logic [3:0] {OP_CHIP_ERASE, OP_ERASE_SUSPEND, OP_ERASE_RESUME, OP_PROG_SUSPEND,
                            OP_PROG_RESUME, OP_ID_READ, OP_SECURE_READ, OP_ARRAY_READ, OP_POLL} op_t;
  typedef enum logic [1:0] {M_READ, M_CHIP, M_ESUSP, M_PSUSP} mode_t;
  typedef enum {S_IDLE, S_STEP, S_WAIT, S_GAP, S_SUSP, S_RST_LO, S_RST_HI} state_t;
  typedef enum {C_IDLE, C_SET, C_STB, C_REC} cyc_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
    logic        rd;
    logic        last;
  } step_t;
endpackage

//--- rtl/flash_bus_if.sv
// one bus-cycle request/answer between the sequencer and the pin driver
`timescale 1ns/1ps
interface flash_bus_if #(parameter int ADDR_W = 24) ();
  logic              req;    // one-cycle request pulse
  logic              wr;     // 1 write, 0 read
  logic [ADDR_W-1:0] addr;   // word address
  logic [15:0]       wdata;  // write data
  logic              ack;    // one-cycle end of cycle
  logic [15:0]       rdata;  // read data, valid with ack
  modport master (output req, wr, addr, wdata, input ack, rdata);
  modport slave  (input req, wr, addr, wdata, output ack, rdata);
endinterface

//--- rtl/flash_bus_cycle.sv
// drives one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`include "nor_seq_params.svh"
module flash_bus_cycle import nor_seq_pkg::*; #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_b_in,
  flash_bus_if.slave             bus,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [15:0]            dq_out,
  output logic                   dq_oe_out,
  input  wire logic [15:0]       dq_in,
  output logic                   ce_n_out,
  output logic                   oe_n_out,
  output logic                   we_n_out
);
  cyc_state_t        st, next_st;         // cycle phase
  logic [7:0]        cnt, next_cnt;       // phase timer
  logic              wr, next_wr;         // latched direction
  logic [ADDR_W-1:0] next_addr;
  logic [15:0]       next_dq, next_rdata, rdata;
  logic              next_oe, next_ce_n, next_oe_n, next_we_n, next_ack, ack;
  logic [15:0]       dq_s1, dq_s2, dq_s3; // pin synchroniser, only s2/s3 are compared

  assign bus.ack   = ack;
  assign bus.rdata = rdata;

  // phase sequencing; a read waits until the synchronised bus is steady
  always_comb begin
    next_st = st; next_cnt = cnt + 8'h01; next_wr = wr; next_addr = addr_out;
    next_dq = dq_out; next_oe = dq_oe_out; next_ce_n = ce_n_out;
    next_oe_n = oe_n_out; next_we_n = we_n_out; next_ack = 1'b0; next_rdata = rdata;
    unique case (st)
      C_IDLE: begin
        next_cnt = 8'h00;
        if (bus.req) begin
          next_wr = bus.wr; next_addr = bus.addr; next_dq = bus.wdata;
          next_oe = bus.wr; next_ce_n = 1'b0; next_st = C_SET;
        end
      end
      C_SET: if (cnt == `SETUP_CYC - 8'h01) begin
        next_cnt = 8'h00; next_st = C_STB;
        if (wr) next_we_n = 1'b0;
        else next_oe_n = 1'b0;
      end
      C_STB: begin
        // write strobe width; rising edge latches the command
        if (wr && cnt == `WP_CYC - 8'h01) begin
          next_we_n = 1'b1; next_cnt = 8'h00; next_st = C_REC;
        end else if (!wr && cnt >= `ACC_CYC + 8'h02 && dq_s2 == dq_s3) begin
          next_rdata = dq_s3; next_oe_n = 1'b1; next_cnt = 8'h00; next_st = C_REC;
        end else if (!wr && cnt == 8'hff) begin
          next_cnt = cnt;  // hold the timer at top while data settles
        end
      end
      C_REC: if (cnt == `REC_CYC - 8'h01) begin
        next_ce_n = 1'b1; next_oe = 1'b0; next_ack = 1'b1; next_st = C_IDLE;
      end
    endcase
  end

  // registers, pins idle high and released during reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= C_IDLE; cnt <= 8'h00; wr <= 1'b0; addr_out <= '0; dq_out <= 16'h0000;
      dq_oe_out <= 1'b0; ce_n_out <= 1'b1; oe_n_out <= 1'b1; we_n_out <= 1'b1;
      ack <= 1'b0; rdata <= 16'h0000;
      dq_s1 <= 16'h0000; dq_s2 <= 16'h0000; dq_s3 <= 16'h0000;
    end else begin
      st <= next_st; cnt <= next_cnt; wr <= next_wr; addr_out <= next_addr; dq_out <= next_dq;
      dq_oe_out <= next_oe; ce_n_out <= next_ce_n; oe_n_out <= next_oe_n; we_n_out <= next_we_n;
      ack <= next_ack; rdata <= next_rdata;
      dq_s1 <= dq_in; dq_s2 <= dq_s1; dq_s3 <= dq_s2;
    end
  end

  a_we_width: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(we_n_out) |-> !we_n_out [*7]) else $error("write strobe too short");
  a_write_drive: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !we_n_out |-> dq_oe_out && oe_n_out && !ce_n_out) else $error("write strobe without drive");
endmodule

//--- rtl/nor_erase_suspend_sequencer.sv
// host-side sequencer for chip erase and erase/program suspend and resume
`timescale 1ns/1ps
`include "nor_seq_params.svh"
// Operation
// - six unlock/setup writes launch chip erase
// - hardware reset aborts; host reissues chip erase
// - erase suspend is one B0 write, sector erase
// - erase resume one 30 write; extras ignored
// - secure region read needs entry and exit
// - program resume one 30 write; extras ignored
module nor_erase_suspend_sequencer import nor_seq_pkg::*; #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_b_in,
  input  wire logic              cmd_valid_in,
  input  wire logic [3:0]        cmd_op_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  output logic                   cmd_ready_out,
  input  wire logic              hw_reset_in,
  output logic                   done_out,
  output logic                   refused_out,
  output logic                   timeout_out,
  output logic                   erase_done_out,
  output logic [15:0]            rdata_out,
  output logic [1:0]             mode_out,
  output logic [ADDR_W-1:0]      flash_addr_out,
  output logic [15:0]            flash_dq_out,
  output logic                   flash_dq_oe_out,
  input  wire logic [15:0]       flash_dq_in,
  output logic                   flash_ce_n_out,
  output logic                   flash_oe_n_out,
  output logic                   flash_we_n_out,
  output logic                   flash_reset_n_out,
  input  wire logic              ready_busy_n_in
);
  localparam int SUSP_MAX = 4000;  // helper bound for the wait checker

  if (ADDR_W < 12) begin : g_chk
    $error("ADDR_W must cover the unlock addresses");
  end

  flash_bus_if #(.ADDR_W(ADDR_W)) bus ();

  flash_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .bus        (bus.slave),
    .addr_out   (flash_addr_out),
    .dq_out     (flash_dq_out),
    .dq_oe_out  (flash_dq_oe_out),
    .dq_in      (flash_dq_in),
    .ce_n_out   (flash_ce_n_out),
    .oe_n_out   (flash_oe_n_out),
    .we_n_out   (flash_we_n_out)
  );

  state_t            st, next_st;         // sequencer state
  mode_t             mode, next_mode;     // what the device is believed to do
  op_t               op, next_op;         // operation under way
  logic [3:0]        step, next_step;     // index into the write list
  logic [15:0]       cnt, next_cnt;       // gap, wait and reset timer
  logic [ADDR_W-1:0] addr_q, next_addr_q; // user address for reads and polling
  logic              from_es, next_from_es; // program was suspended inside erase suspend
  logic              reissue, next_reissue; // chip erase to be run again after reset
  logic              req, next_req, next_ready, next_done, next_refused, next_timeout, next_edone;
  logic [15:0]       next_rdata;
  logic              next_rst_n;
  logic              rb_s1, rb_s2, rb_s3, rb_ready; // ready/busy synchroniser and settled level
  logic              next_rb_ready;                 // settled level once stages two and three agree
  logic              allowed;
  step_t             cur;

  assign bus.req   = req;
  assign bus.wr    = !cur.rd;
  assign bus.addr  = cur.rd ? addr_q : ADDR_W'(cur.addr);
  assign bus.wdata = cur.data;
  assign mode_out  = mode;

  // write list for each operation; a read step uses the latched user address
  function automatic step_t step_word(input op_t o, input logic [3:0] i);
    step_t s;
    s = '{addr: `ADDR_UNLK1, data: `CMD_UNLK1, rd: 1'b0, last: 1'b0};
    if (i == 4'h1 || (o == OP_SECURE_READ && i == 4'h5)) begin
      s.addr = `ADDR_UNLK2;
      s.data = `CMD_UNLK2;
    end
    unique case (o)
      OP_CHIP_ERASE: begin
        if (i == 4'h2) s.data = `CMD_SETUP;
        if (i == 4'h4) begin
          s.addr = `ADDR_UNLK2;
          s.data = `CMD_UNLK2;
        end
        if (i == 4'h5) begin
          s.data = `CMD_CHIP;
          s.last = 1'b1;
        end
      end
      OP_ERASE_SUSPEND, OP_PROG_SUSPEND: s = '{`ADDR_ANY, `CMD_SUSPEND, 1'b0, 1'b1};
      OP_ERASE_RESUME, OP_PROG_RESUME: s = '{`ADDR_ANY, `CMD_RESUME, 1'b0, 1'b1};
      OP_ID_READ: begin
        if (i == 4'h2) s.data = `CMD_ID_ENTRY;
        if (i == 4'h3) s.rd = 1'b1;
        if (i == 4'h4) s = '{`ADDR_ANY, `CMD_READ_RST, 1'b0, 1'b1};
      end
      OP_SECURE_READ: begin
        if (i == 4'h2) s.data = `CMD_SEC_ENTRY;
        if (i == 4'h3) s.rd = 1'b1;
        if (i == 4'h6) s.data = `CMD_ID_ENTRY;
        if (i == 4'h7) s = '{`ADDR_ANY, `CMD_SEC_EXIT, 1'b0, 1'b1};
      end
      OP_ARRAY_READ, OP_POLL: begin
        s.rd = 1'b1;
        s.last = 1'b1;
      end
    endcase
    return s;
  endfunction

  always_comb cur = step_word(op, step);

  // which user commands make sense in the believed device mode
  always_comb begin
    unique case (op_t'(cmd_op_in))
      OP_CHIP_ERASE, OP_ERASE_SUSPEND: allowed = (mode == M_READ);
      OP_ERASE_RESUME: allowed = (mode == M_ESUSP);
      OP_PROG_SUSPEND: allowed = (mode == M_READ) || (mode == M_ESUSP);
      OP_PROG_RESUME: allowed = (mode == M_PSUSP);
      OP_ID_READ, OP_SECURE_READ, OP_ARRAY_READ: allowed = 1'b1;
      default: allowed = 1'b0;  // internal or unknown codes are refused
    endcase
  end

  // sequencer next state
  always_comb begin
    next_st = st; next_mode = mode; next_op = op; next_step = step; next_cnt = cnt + 16'h0001;
    next_addr_q = addr_q; next_from_es = from_es; next_reissue = reissue; next_req = 1'b0;
    next_done = 1'b0; next_refused = 1'b0; next_timeout = 1'b0; next_edone = 1'b0;
    next_rdata = rdata_out; next_rst_n = flash_reset_n_out;
    next_rb_ready = (rb_s2 == rb_s3) ? rb_s3 : rb_ready;
    unique case (st)
      S_IDLE: begin
        next_cnt = 16'h0000;
        if (hw_reset_in) begin
          next_rst_n = 1'b0; next_st = S_RST_LO;
        end else if (cmd_valid_in) begin
          // only a legal code reaches op, so the step decoder never meets an unknown value
          if (allowed) begin
            next_op = op_t'(cmd_op_in); next_addr_q = cmd_addr_in; next_step = 4'h0; next_st = S_STEP;
          end else begin
            next_done = 1'b1; next_refused = 1'b1; // extra resumes and bad commands go nowhere
          end
        end
      end
      S_STEP: begin
        next_req = 1'b1; next_st = S_WAIT;
      end
      S_WAIT: if (bus.ack) begin
        next_cnt = 16'h0000;
        if (cur.rd) next_rdata = bus.rdata;
        if (!cur.last) begin
          next_step = step + 4'h1; next_st = S_STEP;
        end else begin
          next_st = S_IDLE;
          next_done = 1'b1;
          unique case (op)
            OP_CHIP_ERASE: begin // erase launched, device preprograms itself; only polling
              next_mode = M_CHIP; next_done = 1'b0; next_st = S_GAP;
            end
            OP_POLL: // polling bit high and ready level means erase ended
              if (bus.rdata[`DATA_POLL_POS] && rb_ready) begin
                next_mode = M_READ; next_edone = 1'b1;
              end else begin
                next_done = 1'b0; next_st = S_GAP;
              end
            OP_ERASE_SUSPEND, OP_PROG_SUSPEND: begin
              next_done = 1'b0; next_st = S_SUSP;
              next_from_es = (op == OP_PROG_SUSPEND) ? (mode == M_ESUSP) : from_es;
            end
            OP_ERASE_RESUME: next_mode = M_READ;
            OP_PROG_RESUME: next_mode = from_es ? M_ESUSP : M_READ;
            default: next_mode = mode;
          endcase
        end
      end
      S_GAP: begin // poll interval; a reset here aborts the erase
        if (hw_reset_in) begin
          next_rst_n = 1'b0; next_reissue = 1'b1; next_cnt = 16'h0000; next_st = S_RST_LO;
        end else if (cnt == `POLL_CYC - 16'h0001) begin
          next_op = OP_POLL; next_step = 4'h0; next_st = S_STEP;
        end
      end
      S_SUSP: begin // wait for ready within the suspend bound
        if (rb_ready) begin
          next_mode = (op == OP_ERASE_SUSPEND) ? M_ESUSP : M_PSUSP; next_done = 1'b1; next_st = S_IDLE;
        end else if (cnt == ((op == OP_ERASE_SUSPEND) ? `ESUSP_CYC : `PSUSP_CYC) - 16'h0001) begin
          next_timeout = 1'b1; next_done = 1'b1; next_st = S_IDLE;
        end
      end
      S_RST_LO: if (cnt == `RST_CYC - 16'h0001) begin
        next_rst_n = 1'b1; next_cnt = 16'h0000; next_st = S_RST_HI;
      end
      S_RST_HI: if (cnt == `RH_CYC - 16'h0001) begin
        next_mode = M_READ; next_from_es = 1'b0;
        if (reissue) begin // run the full erase again once the array reads
          next_reissue = 1'b0; next_op = OP_CHIP_ERASE; next_step = 4'h0; next_st = S_STEP;
        end else begin
          next_done = 1'b1; next_st = S_IDLE;
        end
      end
    endcase
    next_ready = (next_st == S_IDLE);
  end

  // registers; ready/busy settles once the second and third stages agree
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= S_IDLE; mode <= M_READ; op <= OP_ARRAY_READ; step <= 4'h0; cnt <= 16'h0000;
      addr_q <= '0; from_es <= 1'b0; reissue <= 1'b0; req <= 1'b0; cmd_ready_out <= 1'b0;
      done_out <= 1'b0; refused_out <= 1'b0; timeout_out <= 1'b0; erase_done_out <= 1'b0;
      rdata_out <= 16'h0000; flash_reset_n_out <= 1'b1;
      rb_s1 <= 1'b1; rb_s2 <= 1'b1; rb_s3 <= 1'b1; rb_ready <= 1'b1; // pin idles at ready
    end else begin
      st <= next_st; mode <= next_mode; op <= next_op; step <= next_step; cnt <= next_cnt;
      addr_q <= next_addr_q; from_es <= next_from_es; reissue <= next_reissue; req <= next_req;
      cmd_ready_out <= next_ready; done_out <= next_done; refused_out <= next_refused;
      timeout_out <= next_timeout; erase_done_out <= next_edone; rdata_out <= next_rdata;
      flash_reset_n_out <= next_rst_n;
      rb_s1 <= ready_busy_n_in; rb_s2 <= rb_s1; rb_s3 <= rb_s2;
      rb_ready <= next_rb_ready;
    end
  end

  a_chip_cmd_addr: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    bus.req && bus.wr && op == OP_CHIP_ERASE && step == 4'h5 |-> bus.wdata == `CMD_CHIP && bus.addr == ADDR_W'(`ADDR_UNLK1))
    else $error("chip erase command at wrong address");
  a_chip_busy_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    mode == M_CHIP |-> !cmd_ready_out) else $error("commands offered during chip erase");
  a_erase_done_poll: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    erase_done_out |-> rdata_out[7] && mode == M_READ && done_out) else $error("erase end without status");
  a_rst_pulse_len: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(flash_reset_n_out) |-> !flash_reset_n_out [*8]) else $error("flash reset pulse too short");
  a_reset_reissue: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    st == S_GAP && hw_reset_in |=> reissue) else $error("aborted erase not marked for reissue");
  a_resume_ignored: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cmd_valid_in && cmd_ready_out && cmd_op_in == 4'(OP_ERASE_RESUME) && mode != M_ESUSP
    |=> refused_out && done_out) else $error("stray erase resume not refused");
  a_prog_resume: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cmd_valid_in && cmd_ready_out && cmd_op_in == 4'(OP_PROG_RESUME) && mode == M_PSUSP
    |-> ##[1:100] mode != M_PSUSP) else $error("program resume did not leave suspend");
  a_susp_bound: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    st == S_SUSP |-> cnt < 16'(SUSP_MAX)) else $error("suspend wait overran");
  a_timeout_src: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    timeout_out |-> $past(st) == S_SUSP && done_out) else $error("timeout outside suspend wait");
endmodule

//--- testbench/flash_dev_model.sv
// behavioural flash device answering the sequencer's pin cycles
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] ID_CODE   = 16'h1234, // arbitrary identification word
  parameter logic [15:0] SEC_WORD  = 16'h0c3e, // secure region content
  parameter int          ERASE_CYC = 3000      // embedded erase length in cycles
) (
  input  wire logic        clk_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        reset_n_in,
  output logic             ready_busy_n_out
);
  localparam logic [27:0] SEQ [6] = '{28'h55500aa, 28'h2aa0055, 28'h5550080, 28'h55500aa, 28'h2aa0055, 28'h5550010};
  int          erase_cnt, susp_cnt, susp_delay = 20, depth, erase_runs; // timers, suspend nesting
  bit          erased, id_m, sec_m, tgl, we_q = 1, oe_q = 1;             // modes and edge history
  logic [15:0] last = 16'h0000;                                          // released bus shows its inverse
  logic [27:0] wr_log [$];                                               // every write, address and data
  logic [15:0] word;                                                     // value offered on a read
  // mode words first, then erase status, then suspended-sector status, then array
  always_comb begin
    if (sec_m) word = SEC_WORD;
    else if (id_m) word = ID_CODE;
    else if (erase_cnt > 0) word = {8'h00, 1'b0, tgl, 3'b000, tgl, 2'b00};
    else if (depth > 0 && addr_in[23:16] == 8'h00) word = {8'h00, 1'b1, 1'b0, 3'b000, tgl, 2'b00};
    else word = erased ? 16'hffff : 16'h5a5a;
  end
  // no pull on the data lines, so an idle bus must not look like the last word
  assign dq_out = (!ce_n_in && !oe_n_in) ? word : ~last;
  assign ready_busy_n_out = !(erase_cnt > 0 || susp_cnt > 0);
  // true when the last six writes form the whole-array erase sequence
  function automatic bit chip_seq();
    int n;
    n = wr_log.size();
    if (n < 6) return 0;
    for (int i = 0; i < 6; i++) if (wr_log[n-6+i] !== SEQ[i]) return 0;
    return 1;
  endfunction
  // pin decoding; a write lands on the rising write strobe
  always @(posedge clk_in) begin
    we_q <= we_n_in;
    oe_q <= oe_n_in;
    if (!ce_n_in && !oe_n_in) last <= word;
    if (oe_q && !oe_n_in) tgl <= !tgl; // status bits toggle per read
    if (!reset_n_in) begin // hardware reset aborts at once
      erase_cnt <= 0;
      susp_cnt <= 0;
      depth <= 0;
      id_m <= 0;
      sec_m <= 0;
    end else begin
      if (erase_cnt > 0) erase_cnt <= erase_cnt - 1;
      if (erase_cnt == 1) erased <= 1; // back to array read
      if (susp_cnt > 0) susp_cnt <= susp_cnt - 1;
      if (!we_q && we_n_in && !ce_n_in) begin
        wr_log.push_back({addr_in[11:0], dq_in});
        if (erase_cnt == 0) begin // writes during erase are dropped
          case (dq_in)
            16'h0010: if (chip_seq()) begin
              erase_cnt <= ERASE_CYC;
              erased <= 0;
              erase_runs <= erase_runs + 1;
            end
            16'h00b0: begin // settles after a chosen delay
              susp_cnt <= susp_delay;
              depth <= depth + 1;
            end
            16'h0030: if (depth > 0) depth <= depth - 1; // spare resumes ignored
            16'h0090: id_m <= 1;
            16'h0088: sec_m <= 1;
            16'h00f0, 16'h0000: begin
              id_m <= 0;
              sec_m <= 0;
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule

//--- testbench/nor_erase_suspend_sequencer_tb.sv
// self-checking bench for the erase/suspend sequencer against the flash model
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module nor_erase_suspend_sequencer_tb;
  localparam logic [15:0] SEC_WORD = 16'h0c3e; // secure region content
  logic        clk_sys_in = 0, rst_b_in = 0, cmd_valid_in = 0, hw_reset_in = 0;
  logic [3:0]  cmd_op_in = 4'h7;
  logic [23:0] cmd_addr_in = 24'h010000;
  wire         cmd_ready_out, done_out, refused_out, timeout_out, erase_done_out, flash_dq_oe_out;
  wire         flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_reset_n_out, ready_busy_n_in;
  wire  [15:0] rdata_out, flash_dq_out, dev_dq, flash_dq_in;
  wire  [1:0]  mode_out;
  wire  [23:0] flash_addr_out;
  int          err_count, samples_checked, mode_m, psusp_from, rst_lo, n0; // bench model state
  bit          erased_m;                                                   // array erased once
  int          tab [18] = '{1, 7, 7, 0, 1, 4, 5, 3, 3, 2, 5, 6, 4, 4, 2, 2, 1, 2}; // suspend walk
  // whoever enables its driver owns the data wire
  assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : dev_dq;
  nor_erase_suspend_sequencer dut_u (.clk_sys_in, .rst_b_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_in,
    .cmd_ready_out, .hw_reset_in, .done_out, .refused_out, .timeout_out, .erase_done_out, .rdata_out,
    .mode_out, .flash_addr_out, .flash_dq_out, .flash_dq_oe_out, .flash_dq_in, .flash_ce_n_out,
    .flash_oe_n_out, .flash_we_n_out, .flash_reset_n_out, .ready_busy_n_in);
  flash_dev_model #(.SEC_WORD(SEC_WORD)) flash_u (.clk_in(clk_sys_in), .addr_in(flash_addr_out),
    .dq_in(flash_dq_in), .dq_out(dev_dq), .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
    .we_n_in(flash_we_n_out), .reset_n_in(flash_reset_n_out), .ready_busy_n_out(ready_busy_n_in));
  always #2.5 clk_sys_in = ~clk_sys_in;
  // mid-cycle sampling avoids racing the register update
  always @(negedge clk_sys_in) if (flash_reset_n_out === 1'b0) rst_lo++;
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wait_ready();
    repeat (8) if (cmd_ready_out !== 1'b1) step();
  endtask
  // bounded wait for the completion pulse; it stands one cycle only
  task automatic wait_done();
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 30000) begin
      step();
      n++;
    end
    if (n == 30000) err_count++;
  endtask
  function automatic bit refused_f(int op);
    case (op)
      0, 1: return mode_m != 0;
      2: return mode_m != 2;
      3: return mode_m == 1 || mode_m == 3;
      4: return mode_m != 3;
      5, 6, 7: return 0;
      default: return 1;
    endcase
  endfunction
  function automatic logic [23:0] rnd();
    return {8'h01 + 8'($urandom % 200), 16'($urandom)};
  endfunction
  // one command through the handshake, then every result against the bench model
  task automatic run(input logic [3:0] op, input logic [23:0] a, input bit to = 0);
    bit          rf;
    logic [15:0] ed, msk;
    rf = refused_f(op);
    msk = 16'hffff;
    ed = (erased_m || op == 0) ? 16'hffff : 16'h5a5a;
    if (op == 5) ed = flash_u.ID_CODE;
    else if (op == 6) ed = SEC_WORD;
    else if (op == 7 && a[23:16] == 8'h00 && mode_m >= 2) begin
      ed = 16'h0080; // suspended sector shows status only
      msk = 16'hff80;
    end
    step(); // let an edge pass between two commands
    wait_ready();
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_valid_in = 1;
    step();
    cmd_valid_in = 0;
    wait_done();
    `CHK(refused_out, rf)
    `CHK(timeout_out, to)
    `CHK(erase_done_out, 1'(op == 0 && !rf))
    if (!rf && !to) case (op)
      0: erased_m = 1;
      1: mode_m = 2;
      2: mode_m = 0;
      3: begin
        psusp_from = mode_m;
        mode_m = 3;
      end
      4: mode_m = psusp_from;
      default: ;
    endcase
    if (!rf && (op == 0 || (op >= 5 && op <= 7))) `CHK(rdata_out & msk, ed & msk)
    `CHK(mode_out, 2'(mode_m))
  endtask
  task automatic hw_rst();
    int r0;
    wait_ready();
    r0 = rst_lo;
    hw_reset_in = 1;
    step();
    hw_reset_in = 0;
    wait_done();
    mode_m = 0;
    `CHK(rst_lo - r0, 100)
    `CHK(mode_out, 2'b00)
  endtask
  initial begin
    #450000;
    err_count++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hb551));
    repeat (6) step();
    rst_b_in = 1;
    repeat (2) step();
    run(4'h7, rnd());
    run(4'h2, rnd());
    run(4'h4, rnd());
    repeat (4) run(4'(8 + $urandom % 8), rnd());
    // erase cut by a hardware reset, reissued and finished
    n0 = flash_u.wr_log.size();
    fork
      run(4'h0, rnd());
      begin
        repeat (1500) step();
        `CHK(cmd_ready_out, 1'b0)
        `CHK(mode_out, 2'b01)
        hw_reset_in = 1; // level held until taken; a poll read in flight delays it
        repeat (64) if (flash_reset_n_out !== 1'b0) step();
        hw_reset_in = 0;
        `CHK(flash_reset_n_out, 1'b0)
      end
    join
    `CHK(flash_u.erase_runs, 2)
    for (int i = 0; i < 12; i++) `CHK(flash_u.wr_log[n0+i], flash_u.SEQ[i%6])
    run(4'h7, rnd());
    hw_rst();
    flash_u.susp_delay = 20 + $urandom % 180;
    foreach (tab[i]) run(4'(tab[i]), i == 1 ? 24'h000123 : rnd());
    flash_u.susp_delay = 3500;
    run(4'h3, rnd(), 1);
    hw_rst();
    run(4'h1, rnd());
    run(4'h2, rnd());
    flash_u.susp_delay = 4500;
    run(4'h1, rnd(), 1);
    hw_rst();
    finish_test();
  end
endmodule
